// *** core/sdpc_top.sv ***
/*
  Stereo DAC power control and volume link / reference rate registers.
  Assumes a word-level register port fed by the serial host port decoder on
  the same clock, and volume and rate-code values from neighbouring registers.
*/
`timescale 1ns/1ps
module sdpc_top #(
  parameter int SETTLE_CYC = sdpc_pkg::PDN_SETTLE_CYC,
  parameter int VOL_W = 7
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Register port
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [6:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  // Values from neighbouring registers
  input wire logic [VOL_W-1:0] i_left_vol,
  input wire logic [VOL_W-1:0] i_right_vol,
  input wire logic [5:0] i_rate_code,
  // Analog and filter controls
  output logic o_codec_pdn,
  output logic o_hp_drv_en,
  output logic o_dac_pdn,
  output logic o_virtual_ground_pdn,
  output logic o_bass_en,
  output logic o_deemph_en,
  output logic o_pdn_done,
  // Volume and rate
  output logic [VOL_W-1:0] o_left_vol,
  output logic [VOL_W-1:0] o_right_vol,
  output logic o_ref_44k1,
  output logic [2:0] o_rate_div
);

  logic codec_pdn_q;
  logic drv_sel_q;
  logic dac_pdn_q;
  logic virtual_ground_pdn_q;
  logic bass_q;
  logic deemph_q;
  logic [1:0] link_q;
  logic ref_rate_q;
  logic pdn_done;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic [VOL_W-1:0] left_q;
  logic [VOL_W-1:0] right_q;
  logic [2:0] div_q;
  logic [15:0] pwr_word;
  logic [15:0] rate_word;
  logic wr_pwr;
  logic wr_rate;

  // Codes outside the table fall back to divide-by-one
  function automatic logic [2:0] rate_divisor(input logic [5:0] code);
    case (code)
      6'h00: rate_divisor = 3'h1;
      6'h09: rate_divisor = 3'h2;
      6'h12: rate_divisor = 3'h2;
      6'h1B: rate_divisor = 3'h3;
      6'h24: rate_divisor = 3'h4;
      6'h2D: rate_divisor = 3'h5;
      6'h36: rate_divisor = 3'h6;
      6'h3F: rate_divisor = 3'h6;
      default: rate_divisor = 3'h1;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction

  assign wr_pwr = i_wr && addr_hit(i_addr, sdpc_pkg::PWR_CTRL_ADDR);
  assign wr_rate = i_wr && addr_hit(i_addr, sdpc_pkg::VOL_RATE_ADDR);

  assign o_codec_pdn = codec_pdn_q;
  assign o_hp_drv_en = drv_sel_q;
  assign o_dac_pdn = dac_pdn_q;
  assign o_virtual_ground_pdn = virtual_ground_pdn_q;
  assign o_bass_en = bass_q;
  assign o_deemph_en = deemph_q;
  assign o_pdn_done = pdn_done;
  assign o_left_vol = left_q;
  assign o_right_vol = right_q;
  assign o_ref_44k1 = ref_rate_q;
  assign o_rate_div = div_q;
  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Power control register: only the writable bits are stored
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      codec_pdn_q <= sdpc_pkg::PWR_CODEC_PDN_RST;
      drv_sel_q <= sdpc_pkg::PWR_DRV_SEL_RST;
      dac_pdn_q <= sdpc_pkg::PWR_DAC_PDN_RST;
      virtual_ground_pdn_q <= sdpc_pkg::PWR_VIRTUAL_GROUND_PDN_RST;
      bass_q <= sdpc_pkg::PWR_BASS_RST;
      deemph_q <= sdpc_pkg::PWR_DEEMPH_RST;
    end else if (i_ce && wr_pwr) begin
      codec_pdn_q <= i_wdata[sdpc_pkg::CODEC_PDN_BIT];
      drv_sel_q <= i_wdata[sdpc_pkg::DRV_SEL_BIT];
      dac_pdn_q <= i_wdata[sdpc_pkg::DAC_PDN_BIT];
      virtual_ground_pdn_q <= i_wdata[sdpc_pkg::VIRTUAL_GROUND_PDN_BIT];
      bass_q <= i_wdata[sdpc_pkg::BASS_BIT];
      deemph_q <= i_wdata[sdpc_pkg::DEEMPH_BIT];
    end
  end

  // Volume link and reference rate register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      link_q <= sdpc_pkg::LINK_RST;
      ref_rate_q <= sdpc_pkg::REF_RATE_RST;
    end else if (i_ce && wr_rate) begin
      link_q <= i_wdata[sdpc_pkg::LINK_HI:sdpc_pkg::LINK_LO];
      ref_rate_q <= i_wdata[sdpc_pkg::REF_RATE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The DAC counts as going down whenever the whole codec is down too
  sdpc_pdn_seq #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_pdn_seq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_pdn_req(dac_pdn_q | codec_pdn_q),
    .o_done(pdn_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Effective channel volumes, one cycle behind the inputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      left_q <= '0;
      right_q <= '0;
    end else if (i_ce) begin
      case (link_q)
        sdpc_pkg::LINK_USE_RIGHT: begin
          left_q <= i_right_vol;
          right_q <= i_right_vol;
        end
        sdpc_pkg::LINK_USE_LEFT: begin
          left_q <= i_left_vol;
          right_q <= i_left_vol;
        end
        default: begin
          left_q <= i_left_vol;
          right_q <= i_right_vol;
        end
      endcase
    end
  end

  // Divisor applied to the reference rate
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_q <= 3'h1;
    end else if (i_ce) begin
      div_q <= rate_divisor(i_rate_code);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-only bits read their fixed values, whatever was written, except the done bit, which reads the sequencer flag
  always_comb begin
    pwr_word = sdpc_pkg::PWR_RO_FIXED;
    pwr_word[sdpc_pkg::CODEC_PDN_BIT] = codec_pdn_q;
    pwr_word[sdpc_pkg::DRV_SEL_BIT] = drv_sel_q;
    pwr_word[sdpc_pkg::DAC_PDN_BIT] = dac_pdn_q;
    pwr_word[sdpc_pkg::VIRTUAL_GROUND_PDN_BIT] = virtual_ground_pdn_q;
    pwr_word[sdpc_pkg::PDN_DONE_BIT] = pdn_done;
    pwr_word[sdpc_pkg::BASS_BIT] = bass_q;
    pwr_word[sdpc_pkg::DEEMPH_BIT] = deemph_q;
    rate_word = 16'h0000;
    rate_word[sdpc_pkg::LINK_HI:sdpc_pkg::LINK_LO] = link_q;
    rate_word[sdpc_pkg::REF_RATE_BIT] = ref_rate_q;
  end

  // Unmapped addresses read as zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
    end else if (i_ce) begin
      rvalid_q <= i_rd;
      if (i_rd) begin
        if (addr_hit(i_addr, sdpc_pkg::PWR_CTRL_ADDR)) begin
          rdata_q <= pwr_word;
        end else if (addr_hit(i_addr, sdpc_pkg::VOL_RATE_ADDR)) begin
          rdata_q <= rate_word;
        end else begin
          rdata_q <= 16'h0000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  codec_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr_pwr) |=> o_codec_pdn == $past(i_wdata[15]))
    else $error("codec power-down bit not taken from write");

  drv_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr_pwr) |=> o_hp_drv_en == $past(i_wdata[12]) && o_virtual_ground_pdn == $past(i_wdata[8]))
    else $error("driver controls not taken from write");

  dac_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr_pwr) |=> o_dac_pdn == $past(i_wdata[10]))
    else $error("dac power-down bit not taken from write");

  filter_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr_pwr) |=> o_bass_en == $past(i_wdata[1]) && o_deemph_en == $past(i_wdata[0]))
    else $error("filter enables not taken from write");

  ro_readback_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_rd && i_addr == 7'h05) |=> (o_rdata & 16'h6ABC) == 16'h2AA0 && o_rdata[6] == $past(o_pdn_done))
    else $error("read-only bits of power register wrong");

  link_right_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && link_q == 2'h1) |=> o_left_vol == $past(i_right_vol) && o_right_vol == $past(i_right_vol))
    else $error("left channel not following right volume");

  link_left_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && link_q == 2'h2) |=> o_right_vol == $past(i_left_vol) && o_left_vol == $past(i_left_vol))
    else $error("right channel not following left volume");

  link_indep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && link_q[0] == link_q[1]) |=> o_left_vol == $past(i_left_vol) && o_right_vol == $past(i_right_vol))
    else $error("volumes not independent");

  rate_div_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_rate_code == 6'h24) |=> o_rate_div == 3'h4)
    else $error("rate divisor wrong");

  ref_rate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && wr_rate) |=> o_ref_44k1 == $past(i_wdata[13]))
    else $error("reference rate select not taken from write");

endmodule

// *** core/sdpc_pkg.sv ***
/*
  Shared constants for the stereo DAC power and configuration registers:
  register offsets, field positions, reset values and the power-down settle time.
  Assumes a 100 MHz register clock.
*/
package sdpc_pkg;

  // Register addresses on the host register port
  localparam logic [6:0] PWR_CTRL_ADDR = 7'h05;
  localparam logic [6:0] VOL_RATE_ADDR = 7'h06;

  // Power control field positions
  localparam int CODEC_PDN_BIT = 15;
  localparam int DRV_SEL_BIT = 12;
  localparam int DAC_PDN_BIT = 10;
  localparam int VIRTUAL_GROUND_PDN_BIT = 8;
  localparam int PDN_DONE_BIT = 6;
  localparam int BASS_BIT = 1;
  localparam int DEEMPH_BIT = 0;

  // Read-only bits of the power control register and their fixed values
  localparam logic [15:0] PWR_RO_MASK = 16'h6AFC;
  localparam logic [15:0] PWR_RO_FIXED = 16'h2AA0;

  // Reset values of the writable power control bits and of the read-only done flag
  localparam logic PWR_CODEC_PDN_RST = 1'b1;
  localparam logic PWR_DRV_SEL_RST = 1'b0;
  localparam logic PWR_DAC_PDN_RST = 1'b1;
  localparam logic PWR_VIRTUAL_GROUND_PDN_RST = 1'b1;
  localparam logic PWR_BASS_RST = 1'b0;
  localparam logic PWR_DEEMPH_RST = 1'b0;
  localparam logic PWR_PDN_DONE_RST = 1'b1;

  // Volume link and rate field positions and reset values
  localparam int LINK_HI = 15;
  localparam int LINK_LO = 14;
  localparam int REF_RATE_BIT = 13;
  localparam logic [1:0] LINK_RST = 2'h0;
  localparam logic REF_RATE_RST = 1'b0;

  // Volume link codes
  localparam logic [1:0] LINK_INDEP = 2'h0;
  localparam logic [1:0] LINK_USE_RIGHT = 2'h1;
  localparam logic [1:0] LINK_USE_LEFT = 2'h2;

  // Time for the DAC to settle into power-down
  localparam int CLK_MHZ = 100;
  localparam int PDN_SETTLE_NS = 1000;
  localparam int PDN_SETTLE_CYC = (PDN_SETTLE_NS * CLK_MHZ + 999) / 1000;

endpackage

// *** core/sdpc_pdn_seq.sv ***
/*
  DAC power-down sequencer: reports when a requested power-down has settled.
  Assumes the request comes from logic on the same clock.
*/
`timescale 1ns/1ps
module sdpc_pdn_seq #(
  parameter int SETTLE_CYC = sdpc_pkg::PDN_SETTLE_CYC
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // Power-down request and completion
  input wire logic i_pdn_req,
  output logic o_done
);

  typedef enum logic [1:0] {
    SDPC_UP = 2'b00,
    SDPC_SETTLE = 2'b01,
    SDPC_DOWN = 2'b10
  } sdpc_state_t;

  sdpc_state_t state_q;
  logic [15:0] cnt_q;
  logic done_q;

  assign o_done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= SDPC_DOWN;
      cnt_q <= 16'h0000;
      done_q <= sdpc_pkg::PWR_PDN_DONE_RST;
    end else if (i_ce) begin
      case (state_q)
        SDPC_UP: begin
          done_q <= 1'b0;
          cnt_q <= 16'h0000;
          if (i_pdn_req) begin
            state_q <= SDPC_SETTLE;
          end
        end
        SDPC_SETTLE: begin
          if (!i_pdn_req) begin
            state_q <= SDPC_UP;
          end else if (cnt_q == 16'(SETTLE_CYC - 1)) begin
            state_q <= SDPC_DOWN;
            done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        SDPC_DOWN: begin
          if (!i_pdn_req) begin
            state_q <= SDPC_UP;
            done_q <= 1'b0;
          end
        end
        default: begin
          state_q <= SDPC_DOWN;
          done_q <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag drops the cycle after power-up is asked for
  done_drop_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && !i_pdn_req && state_q == SDPC_DOWN) |=> !o_done)
    else $error("done flag did not drop on power-up");

  // Flag never rises while power is requested on
  done_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ($rose(o_done) && !$past(i_rst)) |-> $past(i_pdn_req) && $past(state_q) == SDPC_SETTLE)
    else $error("done flag rose without a settled power-down");

endmodule

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the DAC power control and volume link / rate registers.
  Assumes sdpc_pkg and sdpc_top are compiled first; drives the register port directly.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int SC = 3;
  localparam logic [6:0] PA = sdpc_pkg::PWR_CTRL_ADDR;
  localparam logic [6:0] VA = sdpc_pkg::VOL_RATE_ADDR;
  typedef struct packed {
    logic [1:0] link;
    logic ref_sel;
    logic [6:0] lv;
    logic [6:0] rv;
    logic [5:0] code;
    logic [2:0] div;
  } sdpc_tb_vrow_t;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [6:0] i_addr = 7'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic [6:0] i_left_vol = 7'h00;
  logic [6:0] i_right_vol = 7'h00;
  logic [5:0] i_rate_code = 6'h00;
  logic [15:0] o_rdata;
  logic o_rvalid, o_codec_pdn, o_hp_drv_en, o_dac_pdn, o_virtual_ground_pdn, o_bass_en, o_deemph_en, o_pdn_done, o_ref_44k1;
  logic [6:0] o_left_vol, o_right_vol;
  logic [2:0] o_rate_div;
  wire [5:0] outs = {o_codec_pdn, o_hp_drv_en, o_dac_pdn, o_virtual_ground_pdn, o_bass_en, o_deemph_en};
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // Reserved fields carry the mandated pattern except the all-ones and all-zeros rows
  logic [15:0] pw [7] = '{16'h2AA1, 16'h2AA2, 16'h3AA0, 16'hAEA0, 16'h2BA0, 16'hFFFF, 16'h0000};
  sdpc_tb_vrow_t vr [9] = '{
    '{2'h0, 1'b0, 7'h11, 7'h22, 6'h00, 3'h1}, '{2'h1, 1'b1, 7'h33, 7'h44, 6'h09, 3'h2},
    '{2'h2, 1'b0, 7'h55, 7'h66, 6'h12, 3'h2}, '{2'h3, 1'b1, 7'h7F, 7'h00, 6'h1B, 3'h3},
    '{2'h1, 1'b0, 7'h01, 7'h7E, 6'h24, 3'h4}, '{2'h2, 1'b1, 7'h40, 7'h3F, 6'h2D, 3'h5},
    '{2'h0, 1'b1, 7'h2A, 7'h55, 6'h36, 3'h6}, '{2'h3, 1'b0, 7'h0F, 7'h70, 6'h3F, 3'h6},
    '{2'h0, 1'b0, 7'h12, 7'h34, 6'h05, 3'h1}};

  sdpc_top #(.SETTLE_CYC(SC), .VOL_W(7)) dut (.i_clk, .i_rst, .i_ce, .i_wr, .i_rd, .i_addr, .i_wdata,
    .o_rdata, .o_rvalid, .i_left_vol, .i_right_vol, .i_rate_code, .o_codec_pdn, .o_hp_drv_en, .o_dac_pdn,
    .o_virtual_ground_pdn, .o_bass_en, .o_deemph_en, .o_pdn_done, .o_left_vol, .o_right_vol, .o_ref_44k1, .o_rate_div);

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Each task sets every strobe once, so back-to-back calls never assign a signal twice per step
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask

  task automatic idle(input int n);
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (n) step();
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_wr = 1'b1;
    i_rd = 1'b0;
    i_addr = a;
    i_wdata = d;
    step();
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    i_wr = 1'b0;
    i_rd = 1'b1;
    i_addr = a;
    step();
    check({15'h0000, o_rvalid}, 16'h0001);
    d = o_rdata;
  endtask

  // Flag must stay low for the settle time, then rise within a few cycles
  task automatic settle();
    int k;
    k = 0;
    idle(0);
    while (o_pdn_done !== 1'b1 && k < 20) begin
      step();
      k++;
    end
    check({15'h0000, (k >= SC) && (k <= SC + 4)}, 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] d;
    sdpc_tb_vrow_t v;
    repeat (5) @(posedge i_clk);
    #1;
    for (int r = 0; r < 2; r++) begin
      i_rst = 1'b0;
      check({10'h000, outs}, 16'h002C);
      check({15'h0000, o_pdn_done}, 16'h0001);
      rd(PA, d);
      check(d, 16'hAFE0);
      rd(VA, d);
      check(d, 16'h0000);
      if (r == 0) begin
        foreach (pw[i]) begin
          wr(PA, pw[i]);
          idle(1);
          check({10'h000, outs}, {10'h000, pw[i][15], pw[i][12], pw[i][10], pw[i][8], pw[i][1:0]});
          rd(PA, d);
          check(d & 16'hFFBF, (pw[i] & 16'h9503) | sdpc_pkg::PWR_RO_FIXED);
        end
        foreach (vr[i]) begin
          v = vr[i];
          i_left_vol = v.lv;
          i_right_vol = v.rv;
          i_rate_code = v.code;
          wr(VA, {v.link, v.ref_sel, 13'h1FFF});
          idle(2);
          check({9'h000, o_left_vol}, {9'h000, (v.link == 2'h1) ? v.rv : v.lv});
          check({9'h000, o_right_vol}, {9'h000, (v.link == 2'h2) ? v.lv : v.rv});
          check({12'h000, o_ref_44k1, o_rate_div}, {12'h000, v.ref_sel, v.div});
          rd(VA, d);
          check(d, {v.link, v.ref_sel, 13'h0000});
        end
        wr(PA, 16'h2EA0);
        settle();
        rd(PA, d);
        check(d, 16'h2EE0);
        wr(PA, 16'h2AA0);
        check({15'h0000, o_pdn_done}, 16'h0001);
        idle(1);
        check({15'h0000, o_pdn_done}, 16'h0000);
        // Power-up request in mid-settle aborts the power-down
        wr(PA, 16'h2EA0);
        wr(PA, 16'h2AA0);
        idle(SC + 6);
        check({15'h0000, o_pdn_done}, 16'h0000);
        wr(PA, 16'hAAA0);
        settle();
        wr(PA, 16'h2AA3);
        rd(PA, d);
        check(d & 16'hFFBF, 16'h2AA3);
        wr(7'h07, 16'hFFFF);
        rd(7'h07, d);
        check(d, 16'h0000);
        i_ce = 1'b0;
        wr(PA, 16'hAEA0);
        i_ce = 1'b1;
        idle(1);
        check({10'h000, outs}, 16'h0003);
        rd(PA, d);
        check(d & 16'hFFBF, 16'h2AA3);
        i_rst = 1'b1;
        idle(2);
      end
    end
    close_out();
  end
endmodule
